// File: rtl/port_pkg.sv
package port_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;

  // ----------------------------------------------------------------
  // data-memory locations of the two ports
  // ----------------------------------------------------------------
  localparam logic [7:0] WAKE_DATA_ADDR = 8'hd0;
  localparam logic [7:0] WAKE_CFG_ADDR = 8'hd1;
  localparam logic [7:0] WAKE_PIN_ADDR = 8'hd2;
  localparam logic [7:0] CTRL_DATA_ADDR = 8'hd4;
  localparam logic [7:0] CTRL_CFG_ADDR = 8'hd5;
  localparam logic [7:0] CTRL_PIN_ADDR = 8'hd6;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // wake port bit positions
  // ----------------------------------------------------------------
  localparam int WAKE_EXT_CLK_BIT = 1;
  localparam int WAKE_TX_BIT = 2;
  localparam int WAKE_RX_BIT = 3;
  localparam int WAKE_T2A_BIT = 4;
  localparam int WAKE_T2B_BIT = 5;
  localparam int WAKE_T3A_BIT = 6;
  localparam int WAKE_T3B_BIT = 7;

  // ----------------------------------------------------------------
  // control port bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_INTR_BIT = 0;
  localparam int CTRL_FAULT_BIT = 1;
  localparam int CTRL_IDLE_BIT = 6;
  localparam int CTRL_HALT_BIT = 7;
  localparam int CTRL_ALT_SK_BIT = 6;
  localparam int CTRL_DELAY_BIT = 7;
  localparam logic [7:0] CTRL_DATA_READ_MASK = 8'h3f;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_HALT = 2'b10
  } power_mode_t;

endpackage : port_pkg

// File: rtl/port_pad_if.sv
`timescale 1ns/100ps
interface port_pad_if;
  import port_pkg::*;
  logic [PORT_W-1:0] cfg;
  logic [PORT_W-1:0] dat;
  logic [PORT_W-1:0] oe;
  logic [PORT_W-1:0] out;
  logic [PORT_W-1:0] pu;
  modport owner (output cfg, output dat, input oe, input out, input pu);
  modport pad (input cfg, input dat, output oe, output out, output pu);
endinterface : port_pad_if

// File: rtl/port_sync.sv
`timescale 1ns/100ps
module port_sync #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  if (W < 1) begin : g_check
    $error("port_sync width must be at least one");
  end

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : port_sync

// File: rtl/port_pad_ctrl.sv
`timescale 1ns/100ps
module port_pad_ctrl (
  port_pad_if.pad pads
);
  import port_pkg::*;

  // ----------------------------------------------------------------
  // per-pin mode decode from configuration and data bits
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    always_comb begin
      pads.oe[i] = pads.cfg[i];
      pads.out[i] = pads.cfg[i] & pads.dat[i];
      pads.pu[i] = ~pads.cfg[i] & pads.dat[i];
    end
  end
endmodule : port_pad_ctrl

// File: rtl/port_config_and_power_mode_bits.sv
`timescale 1ns/100ps
module port_config_and_power_mode_bits #(
  parameter bit HAS_TIMER3 = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  // memory-mapped access
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // wake port pins
  input wire logic [port_pkg::PORT_W-1:0] wake_pin_in,
  output logic [port_pkg::PORT_W-1:0] wake_pin_out,
  output logic [port_pkg::PORT_W-1:0] wake_pin_oe,
  output logic [port_pkg::PORT_W-1:0] wake_pin_pullup,
  // control port pins
  input wire logic [port_pkg::PORT_W-1:0] ctrl_pin_in,
  output logic [port_pkg::PORT_W-1:0] ctrl_pin_out,
  output logic [port_pkg::PORT_W-1:0] ctrl_pin_oe,
  output logic [port_pkg::PORT_W-1:0] ctrl_pin_pullup,
  // oscillator option strap and clock pins
  input wire logic crystal_option,
  input wire logic oscillator_clock_out,
  output logic oscillator_clock_in_pullup,
  output logic oscillator_stop,
  output logic wake_start_delay_enable,
  // wake-up sources and power mode
  input wire logic wake_request,
  input wire logic idle_wake,
  output logic [port_pkg::PORT_W-1:0] multi_input_wakeup,
  output port_pkg::power_mode_t power_mode,
  output logic halt_mode,
  output logic idle_mode,
  // alternate functions
  input wire logic serial_link_tx,
  input wire logic serial_link_tx_en,
  output logic serial_link_ext_clock,
  output logic serial_link_rx,
  output logic timer2_input_a,
  output logic timer2_input_b,
  output logic timer3_input_a,
  output logic timer3_input_b,
  output logic ext_interrupt_level,
  output logic sync_serial_clock_alt,
  input wire logic fault_monitor_output
);
  import port_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] wake_cfg;
  logic [7:0] wake_dat;
  logic [7:0] ctrl_cfg;
  logic [5:0] ctrl_dat;
  logic [7:0] wake_lvl;
  logic [7:0] wake_lvl_prev;
  logic [7:0] ctrl_lvl;
  logic ctrl7_prev;
  logic crystal_sel;
  logic g7_rise;
  logic halt_write;
  logic idle_write;
  logic [7:0] next_rdata;
  power_mode_t next_mode;

  port_pad_if wake_pads ();
  port_pad_if ctrl_pads ();

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if ((PORT_W != 8) || (CTRL_HALT_BIT != PORT_W - 1)) begin : g_check
    $error("port logic is built for eight-bit ports only");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  port_sync #(
    .W(PORT_W)
  ) u_wake_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(wake_pin_in),
    .q(wake_lvl)
  );

  port_sync #(
    .W(PORT_W)
  ) u_ctrl_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(ctrl_pin_in),
    .q(ctrl_lvl)
  );

  // strap followed at all times through its own synchroniser, held low during reset
  port_sync #(
    .W(1)
  ) u_strap_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d(crystal_option),
    .q(crystal_sel)
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  always_comb begin
    halt_write = mem_wr && (mem_addr == CTRL_DATA_ADDR)
                 && mem_wdata[CTRL_HALT_BIT];
    idle_write = mem_wr && (mem_addr == CTRL_DATA_ADDR)
                 && mem_wdata[CTRL_IDLE_BIT];
  end

  // ----------------------------------------------------------------
  // wake port registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_cfg <= CFG_RESET;
      wake_dat <= DATA_RESET;
    end else if (mem_wr) begin
      if (mem_addr == WAKE_CFG_ADDR) begin
        wake_cfg <= mem_wdata;
      end
      if (mem_addr == WAKE_DATA_ADDR) begin
        wake_dat <= mem_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // control port registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_cfg <= CFG_RESET;
      ctrl_dat <= DATA_RESET[5:0];
    end else if (mem_wr) begin
      if (mem_addr == CTRL_CFG_ADDR) begin
        ctrl_cfg <= mem_wdata;
      end
      // bits 6 and 7 are mode commands, not stored
      if (mem_addr == CTRL_DATA_ADDR) begin
        ctrl_dat <= mem_wdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = READ_IDLE;
    case (mem_addr)
      WAKE_CFG_ADDR: next_rdata = wake_cfg;
      WAKE_DATA_ADDR: next_rdata = wake_dat;
      WAKE_PIN_ADDR: next_rdata = wake_lvl;
      CTRL_CFG_ADDR: next_rdata = ctrl_cfg;
      CTRL_DATA_ADDR: next_rdata = {2'b00, ctrl_dat}
                                   & CTRL_DATA_READ_MASK;
      CTRL_PIN_ADDR: next_rdata = ctrl_lvl;
      default: next_rdata = READ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= READ_IDLE;
    end else if (mem_rd) begin
      mem_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // pad mode decode
  // ----------------------------------------------------------------
  always_comb begin
    wake_pads.cfg = wake_cfg;
    wake_pads.dat = wake_dat;
    ctrl_pads.cfg = ctrl_cfg;
    ctrl_pads.dat = {2'b00, ctrl_dat};
  end

  port_pad_ctrl u_wake_pad (
    .pads(wake_pads)
  );

  port_pad_ctrl u_ctrl_pad (
    .pads(ctrl_pads)
  );

  // ----------------------------------------------------------------
  // wake port pins with serial transmit override
  // ----------------------------------------------------------------
  always_comb begin
    wake_pin_oe = wake_pads.oe;
    wake_pin_out = wake_pads.out;
    wake_pin_pullup = wake_pads.pu;
    if (serial_link_tx_en) begin
      wake_pin_oe[WAKE_TX_BIT] = 1'b1;
      wake_pin_out[WAKE_TX_BIT] = serial_link_tx;
      wake_pin_pullup[WAKE_TX_BIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control port pins with dedicated bits
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_pin_oe = ctrl_pads.oe;
    ctrl_pin_out = ctrl_pads.out;
    ctrl_pin_pullup = ctrl_pads.pu;
    // fixed output, data register has no say
    ctrl_pin_oe[CTRL_FAULT_BIT] = 1'b1;
    ctrl_pin_out[CTRL_FAULT_BIT] = fault_monitor_output;
    ctrl_pin_pullup[CTRL_FAULT_BIT] = 1'b0;
    // input only
    ctrl_pin_oe[CTRL_IDLE_BIT] = 1'b0;
    ctrl_pin_out[CTRL_IDLE_BIT] = 1'b0;
    ctrl_pin_pullup[CTRL_IDLE_BIT] = 1'b0;
    // clock out or plain input by oscillator option
    ctrl_pin_oe[CTRL_HALT_BIT] = crystal_sel;
    ctrl_pin_out[CTRL_HALT_BIT] = crystal_sel
                                  & oscillator_clock_out;
    ctrl_pin_pullup[CTRL_HALT_BIT] = 1'b0;
  end

  // ----------------------------------------------------------------
  // edge detection on synchronised levels
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_lvl_prev <= '0;
      ctrl7_prev <= 1'b0;
    end else begin
      wake_lvl_prev <= wake_lvl;
      ctrl7_prev <= ctrl_lvl[CTRL_HALT_BIT];
    end
  end

  always_comb begin
    multi_input_wakeup = wake_lvl ^ wake_lvl_prev;
    g7_rise = ~crystal_sel & ctrl_lvl[CTRL_HALT_BIT]
              & ~ctrl7_prev;
  end

  // ----------------------------------------------------------------
  // power mode state
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = power_mode;
    case (power_mode)
      MODE_RUN: begin
        if (halt_write) begin
          next_mode = MODE_HALT;
        end else if (idle_write) begin
          next_mode = MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (halt_write) begin
          next_mode = MODE_HALT;
        end else if (idle_wake || wake_request) begin
          next_mode = MODE_RUN;
        end
      end
      MODE_HALT: begin
        if (g7_rise || wake_request) begin
          next_mode = MODE_RUN;
        end
      end
      default: next_mode = MODE_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      power_mode <= MODE_RUN;
    end else begin
      power_mode <= next_mode;
    end
  end

  always_comb begin
    halt_mode = (power_mode == MODE_HALT);
    idle_mode = (power_mode == MODE_IDLE);
    oscillator_stop = halt_mode;
    oscillator_clock_in_pullup = halt_mode & crystal_sel;
  end

  // ----------------------------------------------------------------
  // option bits in the control configuration register
  // ----------------------------------------------------------------
  always_comb begin
    sync_serial_clock_alt = ctrl_cfg[CTRL_ALT_SK_BIT];
    wake_start_delay_enable = ~crystal_sel
                              & ctrl_cfg[CTRL_DELAY_BIT];
  end

  // ----------------------------------------------------------------
  // alternate function inputs
  // ----------------------------------------------------------------
  // levels pass two flops, so a level held one cycle is seen
  always_comb begin
    serial_link_ext_clock = wake_lvl[WAKE_EXT_CLK_BIT];
    serial_link_rx = wake_lvl[WAKE_RX_BIT];
    timer2_input_a = wake_lvl[WAKE_T2A_BIT];
    timer2_input_b = wake_lvl[WAKE_T2B_BIT];
    timer3_input_a = HAS_TIMER3 & wake_lvl[WAKE_T3A_BIT];
    timer3_input_b = HAS_TIMER3 & wake_lvl[WAKE_T3B_BIT];
    ext_interrupt_level = ctrl_lvl[CTRL_INTR_BIT];
  end

endmodule : port_config_and_power_mode_bits

// File: verification/port_config_and_power_mode_bits_asserts.sv
`timescale 1ns/100ps
module port_config_and_power_mode_bits_asserts
  import port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [port_pkg::PORT_W-1:0] wake_pin_oe,
  input wire logic [port_pkg::PORT_W-1:0] ctrl_pin_out,
  input wire logic [port_pkg::PORT_W-1:0] ctrl_pin_oe,
  input wire logic oscillator_clock_out,
  input wire logic oscillator_clock_in_pullup,
  input wire logic oscillator_stop,
  input wire logic wake_request,
  input wire logic halt_mode,
  input wire logic idle_mode,
  input wire logic fault_monitor_output
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // power mode writes
  // ----------------------------------------------------------------
  sequence halt_wr;
    mem_wr && mem_addr == CTRL_DATA_ADDR && mem_wdata[7];
  endsequence
  sequence idle_wr;
    mem_wr && mem_addr == CTRL_DATA_ADDR && mem_wdata[7:6] == 2'b01;
  endsequence
  a_cfg_drive_enable: assert property (mem_wr && mem_addr == WAKE_CFG_ADDR
    |=> wake_pin_oe == $past(mem_wdata)) else $error("oe not from cfg");
  a_fault_pin_owner: assert property (ctrl_pin_oe[1]
    && ctrl_pin_out[1] == fault_monitor_output) else $error("bit1 owner");
  a_input_only_bit: assert property (!ctrl_pin_oe[6])
    else $error("bit6 driven");
  a_crystal_clock_out: assert property (ctrl_pin_oe[7]
    |-> ctrl_pin_out[7] == oscillator_clock_out) else $error("clock out");
  a_halt_entry: assert property (halt_wr |=> halt_mode
    && oscillator_stop) else $error("halt not entered");
  a_idle_entry: assert property (idle_wr and !halt_mode
    |=> idle_mode) else $error("idle not entered");
  a_ctrl_read_mask: assert property (mem_rd && mem_addr == CTRL_DATA_ADDR
    |=> mem_rdata[7:6] == 2'b00) else $error("bits 7:6 read");
  a_halt_pullup: assert property (oscillator_clock_in_pullup
    == (halt_mode && ctrl_pin_oe[7])) else $error("clock pullup");
  a_halt_exit: assert property (halt_mode && wake_request && !mem_wr
    |=> !halt_mode) else $error("halt kept");
endmodule : port_config_and_power_mode_bits_asserts

bind port_config_and_power_mode_bits port_config_and_power_mode_bits_asserts
  u_asserts (.ref_clk, .rst, .mem_addr, .mem_wr, .mem_rd, .mem_wdata,
  .mem_rdata, .wake_pin_oe, .ctrl_pin_out, .ctrl_pin_oe, .oscillator_clock_out,
  .oscillator_clock_in_pullup, .oscillator_stop, .wake_request, .halt_mode,
  .idle_mode, .fault_monitor_output);

// File: verification/port_pin_model.sv
`timescale 1ns/100ps
module port_pin_model (
  input wire logic ref_clk,
  input wire logic [7:0] oe,
  input wire logic [7:0] out,
  input wire logic [7:0] pull_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] level
);
  logic [7:0] last = 8'h00;
  // a floating pin shows a changing pattern, not the last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) level[i] = out[i];
      else if (ext_en[i]) level[i] = ext_val[i];
      else if (pull_en[i]) level[i] = 1'b1;
      else level[i] = ~last[i];
    end
  end
  always_ff @(posedge ref_clk) last <= level;
endmodule : port_pin_model

// File: verification/port_config_and_power_mode_bits_bench.sv
`timescale 1ns/100ps
module port_config_and_power_mode_bits_bench;
  import port_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, mem_wr = 1'b0, mem_rd = 1'b0;
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, mem_rdata;
  logic [7:0] wake_pin_in, wake_pin_out, wake_pin_oe, wake_pin_pullup;
  logic [7:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe, ctrl_pin_pullup;
  logic [7:0] wake_ext_en = 8'ha0, wake_ext_val = 8'h80;
  logic [7:0] ctrl_ext_en = 8'h80, ctrl_ext_val = 8'h00;
  logic crystal_option = 1'b0, oscillator_clock_out = 1'b0;
  logic wake_request = 1'b0, idle_wake = 1'b0, fault_monitor_output = 1'b0;
  logic serial_link_tx = 1'b0, serial_link_tx_en = 1'b0;
  logic oscillator_clock_in_pullup, oscillator_stop, wake_start_delay_enable;
  logic [7:0] multi_input_wakeup;
  power_mode_t power_mode;
  logic halt_mode, idle_mode, serial_link_ext_clock, serial_link_rx;
  logic timer2_input_a, timer2_input_b, timer3_input_a, timer3_input_b;
  logic ext_interrupt_level, sync_serial_clock_alt;
  int miscompares = 0, comparisons = 0, hits;

  port_config_and_power_mode_bits u_port_config_and_power_mode_bits (
    .ref_clk, .rst, .mem_addr, .mem_wr, .mem_rd, .mem_wdata, .mem_rdata,
    .wake_pin_in, .wake_pin_out, .wake_pin_oe, .wake_pin_pullup,
    .ctrl_pin_in, .ctrl_pin_out, .ctrl_pin_oe, .ctrl_pin_pullup,
    .crystal_option, .oscillator_clock_out, .oscillator_clock_in_pullup,
    .oscillator_stop, .wake_start_delay_enable, .wake_request, .idle_wake,
    .multi_input_wakeup, .power_mode, .halt_mode, .idle_mode,
    .serial_link_tx, .serial_link_tx_en, .serial_link_ext_clock,
    .serial_link_rx, .timer2_input_a, .timer2_input_b, .timer3_input_a,
    .timer3_input_b, .ext_interrupt_level, .sync_serial_clock_alt,
    .fault_monitor_output);
  port_pin_model u_wake_pins (.ref_clk, .oe(wake_pin_oe), .out(wake_pin_out),
    .pull_en(wake_pin_pullup), .ext_en(wake_ext_en), .ext_val(wake_ext_val),
    .level(wake_pin_in));
  port_pin_model u_ctrl_pins (.ref_clk, .oe(ctrl_pin_oe), .out(ctrl_pin_out),
    .pull_en(ctrl_pin_pullup), .ext_en(ctrl_ext_en), .ext_val(ctrl_ext_val),
    .level(ctrl_pin_in));

  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk) oscillator_clock_out <= ~oscillator_clock_out;

  task automatic check(input string nm, input logic [7:0] e, s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge ref_clk);
    mem_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, e, input string nm);
    @(negedge ref_clk);
    mem_addr = a;
    mem_rd = 1'b1;
    @(negedge ref_clk);
    mem_rd = 1'b0;
    check(nm, e, mem_rdata);
  endtask : rd

  // waits a bounded time for the run mode, then checks it
  task automatic wait_run(input string nm);
    for (int i = 0; i < 8 && (halt_mode | idle_mode) !== 1'b0; i++)
      @(negedge ref_clk);
    check(nm, 8'h00, {6'h00, halt_mode, idle_mode});
  endtask : wait_run

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end

  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    check("wake_oe", 8'h00, wake_pin_oe);
    rd(WAKE_CFG_ADDR, 8'h00, "wake_cfg");
    rd(CTRL_DATA_ADDR, 8'h00, "ctrl_data");
    wr(WAKE_CFG_ADDR, 8'h0f);
    wr(WAKE_DATA_ADDR, 8'h55);
    check("wake_oe", 8'h0f, wake_pin_oe);
    check("wake_pu", 8'h50, wake_pin_pullup);
    check("wake_out", 8'h05, wake_pin_out & 8'h0f);
    rd(WAKE_DATA_ADDR, 8'h55, "wake_data");
    rd(WAKE_PIN_ADDR, 8'hd5, "wake_pins");
    wr(WAKE_PIN_ADDR, 8'h00);
    rd(WAKE_PIN_ADDR, 8'hd5, "wake_pins");
    check("wake_alt", 8'h34, {2'b00, timer3_input_b, timer3_input_a,
      timer2_input_b, timer2_input_a, serial_link_rx,
      serial_link_ext_clock});
    serial_link_tx_en = 1'b1;
    @(negedge ref_clk);
    check("tx_pin", 8'h00, {7'h00, wake_pin_out[2]});
    serial_link_tx_en = 1'b0;
    wake_ext_val = 8'h00;
    hits = 0;
    repeat (6) begin
      @(negedge ref_clk);
      if (multi_input_wakeup[7] === 1'b1) hits++;
    end
    check("wake_pulse", 8'h01, hits[7:0]);
    fault_monitor_output = 1'b1;
    wr(CTRL_CFG_ADDR, 8'hff);
    wr(CTRL_DATA_ADDR, 8'h3d);
    check("ctrl_oe", 8'h3f, ctrl_pin_oe);
    check("ctrl_pu", 8'h00, ctrl_pin_pullup);
    check("ctrl_out", 8'h3f, ctrl_pin_out);
    check("ctrl_opt", 8'h03, {6'h00, sync_serial_clock_alt,
      wake_start_delay_enable});
    wr(CTRL_DATA_ADDR, 8'hfd);
    check("halt", 8'h03, {6'h00, halt_mode, oscillator_stop});
    check("mode", {6'h00, MODE_HALT}, {6'h00, power_mode});
    check("ck_pu", 8'h00, {7'h00, oscillator_clock_in_pullup});
    rd(CTRL_DATA_ADDR, 8'h3d, "ctrl_data");
    check("intr", 8'h01, {7'h00, ext_interrupt_level});
    rd(CTRL_CFG_ADDR, 8'hff, "ctrl_cfg");
    ctrl_ext_val = 8'h80;
    wait_run("pin_wake");
    wr(CTRL_DATA_ADDR, 8'h40);
    check("idle", 8'h01, {6'h00, halt_mode, idle_mode});
    idle_wake = 1'b1;
    @(negedge ref_clk);
    idle_wake = 1'b0;
    wait_run("idle_exit");
    crystal_option = 1'b1;
    repeat (3) @(negedge ref_clk);
    check("dly_off", 8'h00, {7'h00, wake_start_delay_enable});
    wr(CTRL_DATA_ADDR, 8'h80);
    #1;
    check("ck_pu", 8'h01, {7'h00, oscillator_clock_in_pullup});
    check("ck_out", {7'h00, oscillator_clock_out},
      {7'h00, ctrl_pin_out[7]});
    @(negedge ref_clk);
    wake_request = 1'b1;
    @(negedge ref_clk);
    wake_request = 1'b0;
    wait_run("halt_exit");
    conclude();
  end
endmodule : port_config_and_power_mode_bits_bench
